// file: tb/arr_host_model.sv
// partner: serial host master clocking one frame out of the block
`timescale 1ns/100ps
module arr_host_model
(
   // resolved data wire and clock
   input  wire logic sdo,
   output      logic sclk
);
   initial sclk = 1'b0;
   // clock idles at the polarity level and only runs inside frames
   task automatic frame(input logic cpol, input int n, output logic [15:0] w);
      #3;
      sclk = cpol;
      w = 16'h0000;
      #700;
      repeat (n)
      begin
         sclk = ~sclk;
         if (!cpol) w = {w[14:0], sdo};
         #40;
         sclk = ~sclk;
         // inverted receive clock: capture on the rise that follows the clock fall
         if (cpol) w = {w[14:0], sdo};
         #40;
      end
   endtask
endmodule

// file: tb/arr_readout_chk.sv
// checker: port assertions for the result readout block
`timescale 1ns/100ps
module arr_readout_chk
   import arr_pkg::*;
(
   // clock and reset
   input wire logic                clk,
   input wire logic                rst,
   // modes and host pins
   input wire logic                parallel_serial_select,
   input wire arr_pkg::arr_start_e start_variant,
   input wire logic                chip_select_n,
   input wire logic                read_n,
   input wire logic                high_byte_select,
   input wire logic                serial_clock_in,
   // shared data bus
   input wire logic [7:0]          data_out,
   input wire logic [7:0]          data_oe_n
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (rst);
   // saturating age of the last serial clock fall
   logic [3:0] since_fall;
   wire        ser   = !parallel_serial_select;
   wire        rdsel = !chip_select_n && !read_n;
   always_ff @(posedge clk or posedge rst)
      if (rst)
         since_fall <= 4'hF;
      else if ($fell(serial_clock_in))
         since_fall <= 4'h0;
      else if (since_fall != 4'hF)
         since_fall <= since_fall + 4'h1;
   property p_float;
      chip_select_n [*5] |-> &data_oe_n[7:5];
   endproperty
   a_float: assert property (p_float) else $error("pins driven while deselected");
   property p_high;
      (parallel_serial_select && rdsel && high_byte_select) [*6]
         |-> data_out[7:4] == 4'h0 && data_oe_n == 8'h00;
   endproperty
   a_high: assert property (p_high) else $error("high byte not padded");
   property p_hold;
      (parallel_serial_select && rdsel && $stable(high_byte_select)) [*7] |-> $stable(data_out);
   endproperty
   a_hold: assert property (p_hold) else $error("bus moved during read");
   property p_low_pins;
      ser [*3] ##0 !data_oe_n[4] |-> data_out[4:0] == 5'h00;
   endproperty
   a_low_pins: assert property (p_low_pins) else $error("low pins not low");
   property p_shift;
      ser && !data_oe_n[7] && !$past(data_oe_n[7]) && $changed(data_out[7])
         |-> since_fall inside {[4'h1:4'h7]};
   endproperty
   a_shift: assert property (p_shift) else $error("data moved off clock fall");
   property p_lead;
      ser && start_variant == ARR_IMMEDIATE && $fell(chip_select_n) ##1 !chip_select_n [*6]
         |-> !data_oe_n[7] && !data_out[7];
   endproperty
   a_lead: assert property (p_lead) else $error("no leading zero");
   property p_pins;
      (ser && rdsel) [*5] |-> data_oe_n[6:5] == 2'b00;
   endproperty
   a_pins: assert property (p_pins) else $error("clock or strobe floating");
   property p_strobe;
      ser && !data_oe_n[5] && data_out[5] |-> !data_out[7];
   endproperty
   a_strobe: assert property (p_strobe) else $error("strobe off leading bit");
endmodule
bind arr_readout arr_readout_chk arr_readout_chk_i (.*);

// file: tb/arr_readout_test.sv
// testbench: parallel reads and serial frames against a queue model
`timescale 1ns/100ps
module arr_readout_test;
   import arr_pkg::*;
   logic          clk, rst, conv_valid, conv_ready, conv_start, sdo;
   logic          sdo_last = 1'b0;
   logic          parallel_serial_select, chip_select_n, read_n, high_byte_select;
   logic          serial_clock_in;
   arr_result_s   conv_result;
   arr_par_mode_e par_mode;
   arr_start_e    start_variant;
   logic [7:0]    data_out, data_oe_n, d, e;
   logic [15:0]   w;
   logic [11:0]   cur;
   logic [11:0]   q[$];
   int            err_total, comparisons, cyc, sh, starts;
   arr_readout arr_readout_i (.*);
   arr_host_model arr_host_model_i (.sdo(sdo), .sclk(serial_clock_in));
   // a released line must not look like the last bit
   assign sdo = data_oe_n[7] ? ~sdo_last : data_out[7];
   always @(posedge clk) if (!data_oe_n[7]) sdo_last <= data_out[7];
   // every low read and every frame starts one conversion
   always @(negedge clk) if (conv_start === 1'b1) starts++;
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         err_total++;
         end_of_test();
      end
   end
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         err_total++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task end_of_test();
      if (err_total == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task rdy(input logic [15:0] exp);
      @(negedge clk);
      chk(16'(conv_ready), exp);
      @(posedge clk);
   endtask
   task push(input logic [11:0] v);
      logic r;
      conv_valid <= 1'b1;
      conv_result <= '{value: v};
      do
      begin
         @(negedge clk);
         r = conv_ready;
         @(posedge clk);
      end while (!r);
      conv_valid <= 1'b0;
      q.push_back(v);
      @(posedge clk);
   endtask
   task prd(input logic hb, output logic [7:0] dv);
      high_byte_select <= hb;
      chip_select_n <= 1'b0;
      read_n <= 1'b0;
      repeat (9) @(posedge clk);
      dv = data_out;
      chk({8'h00, data_oe_n}, 16'h0000);
      chip_select_n <= 1'b1;
      read_n <= 1'b1;
      repeat (6) @(posedge clk);
   endtask
   initial
   begin
      rst = 1'b1;
      conv_valid = 1'b0;
      conv_result = '0;
      parallel_serial_select = 1'b1;
      par_mode = ARR_SLOW_MEM;
      start_variant = ARR_IMMEDIATE;
      chip_select_n = 1'b1;
      read_n = 1'b1;
      high_byte_select = 1'b0;
      cur = RESULT_RESET;
      void'($urandom(74));
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      repeat (FIFO_DEPTH) push(12'($urandom));
      rdy(16'h0000);
      for (int m = 0; m < 3; m++)
      begin
         par_mode <= arr_par_mode_e'(m);
         repeat (2)
         begin
            if (m == 1) e = cur[7:0];
            cur = q.pop_front();
            if (m != 1) e = cur[7:0];
            prd(1'b0, d);
            chk({8'h00, d}, {8'h00, e});
            repeat (2)
            begin
               prd(1'b1, d);
               chk({8'h00, d}, {12'h000, cur[11:8]});
            end
         end
      end
      rdy(16'h0001);
      repeat (2) push(12'($urandom));
      parallel_serial_select <= 1'b0;
      read_n <= 1'b0;
      for (int i = 0; i < 4; i++)
      begin
         start_variant <= arr_start_e'(i == 1 || i == 2);
         high_byte_select <= 1'($urandom);
         @(posedge clk);
         fork
            arr_host_model_i.frame(i == 2, (i == 3) ? 13 : 16, w);
            begin
               repeat (3) @(posedge clk);
               chip_select_n <= 1'b0;
            end
         join
         @(posedge clk);
         chip_select_n <= 1'b1;
         repeat (12) @(posedge clk);
         cur = q.pop_front();
         sh = (i == 3) ? 3 : (i == 1) ? 1 : 0;
         chk(w & (16'hFFFF >> sh), {1'b0, cur, 3'b000} >> sh);
      end
      rdy(16'h0001);
      chk(16'(starts), 16'h000A);
      end_of_test();
   end
endmodule

// file: verilog/arr_fifo.sv
// file: parameterised valid/ready fifo for conversion results
`timescale 1ns/100ps
module arr_fifo
#(
   parameter int WIDTH = 12,
   parameter int DEPTH = 8
)
(
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // fill side
   input  wire logic             in_valid,
   output      logic             in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // drain side
   output      logic             out_valid,
   input  wire logic             out_ready,
   output      logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr_reg;
   logic [AW-1:0]    rd_ptr_reg;
   logic [AW:0]      count_reg;
   wire              do_push;
   wire              do_pop;

   assign in_ready  = (count_reg != (AW+1)'(DEPTH));
   assign out_valid = (count_reg != '0);
   assign out_data  = mem[rd_ptr_reg];
   assign do_push   = in_valid && in_ready;
   assign do_pop    = out_valid && out_ready;

   always_ff @(posedge clk)
   begin
      if (do_push)
         mem[wr_ptr_reg] <= in_data;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end
      else
      begin
         if (do_push)
            wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
         if (do_pop)
            rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
         if (do_push && !do_pop)
            count_reg <= count_reg + 1'b1;
         else if (do_pop && !do_push)
            count_reg <= count_reg - 1'b1;
      end
   end
endmodule

// file: verilog/arr_pkg.sv
// package: shared constants and carriers for the result readout block
package arr_pkg;
   localparam int RES_W          = 12;
   localparam int BUS_W          = 8;
   localparam int FIFO_DEPTH     = 8;
   // serial frame: one leading zero, 12 bits, then zeros until select rises
   localparam int FRAME_LEAD     = 1;
   localparam int FRAME_BITS     = 16;
   localparam logic [11:0] RESULT_RESET = 12'h000;
   localparam logic [3:0]  HIGH_PAD     = 4'h0;
   localparam logic [4:0]  BITCNT_RESET = 5'h00;
   // least wait from select to first clock falling edge, in ns, for reference only
   localparam int MIN_START_NS   = 625;
   localparam int CLK_PERIOD_NS  = 10;
   localparam int MIN_START_CYC  = (MIN_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef enum logic [1:0] {
      ARR_SLOW_MEM,
      ARR_ROM,
      ARR_ROM_NOSTART
   } arr_par_mode_e;

   typedef enum logic {
      ARR_IMMEDIATE,
      ARR_CLOCK_ALIGNED
   } arr_start_e;

   // one completed conversion result
   typedef struct packed {
      logic [11:0] value;
   } arr_result_s;

   // pin group of the shared data bus
   typedef struct packed {
      logic [7:0] data_out;
      logic [7:0] data_oe_n;
   } arr_bus_s;
endpackage

// file: verilog/arr_readout.sv
// file: result readout over the parallel byte bus or the serial stream
//
// How it works
// - results are 12 bits, bit 11 most significant
// - slow-memory: new low byte, then padded high nibble
// - rom: old low, new high, new low
// - rom without restart: new low then high
// - serial: bit5 frame strobe, bit6 clock out
// - immediate variant drives low at select fall
// - data valid at rise, changes on fall
// - immediate mode 0: zero, 7 msbs, ...
// - aligned variant starts on first clock fall
// - aligned mode 0: hiz, zero, 6 msbs
// - aligned mode 3: zero, 12 bits, three zeros
// - dsp frame: 12 bits then four zeros
// - byte select picks low or padded high
// - serial outputs float while select high
// - trailing zeros until select returns high
// - interface select high parallel, low serial
`timescale 1ns/100ps
module arr_readout
   import arr_pkg::*;
#(
   parameter int FIFO_W = 12,
   parameter int FIFO_D = 8
)
(
   // clock and reset
   input  wire logic                  clk,
   input  wire logic                  rst,
   // results from the converter core
   input  wire arr_pkg::arr_result_s  conv_result,
   input  wire logic                  conv_valid,
   output      logic                  conv_ready,
   // mode and strap inputs
   input  wire logic                  parallel_serial_select,
   input  wire arr_pkg::arr_par_mode_e par_mode,
   input  wire arr_pkg::arr_start_e   start_variant,
   // host pins, asynchronous to clk
   input  wire logic                  chip_select_n,
   input  wire logic                  read_n,
   input  wire logic                  high_byte_select,
   input  wire logic                  serial_clock_in,
   // shared data bus: bit7 data out, bit6 clock out, bit5 strobe
   output      logic [7:0]            data_out,
   output      logic [7:0]            data_oe_n,
   // conversion start request to the core
   output      logic                  conv_start
);
   // two-stage synchronisers for all host pins
   logic [3:0] sync1_reg;
   logic [3:0] sync2_reg;
   logic       sclk_prev_reg;
   logic       cs_prev_reg;
   logic       rd_prev_reg;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         // idle pin levels: select and read high, byte select and clock low
         sync1_reg     <= 4'hC;
         sync2_reg     <= 4'hC;
         sclk_prev_reg <= 1'b0;
         cs_prev_reg   <= 1'b1;
         rd_prev_reg   <= 1'b1;
      end
      else
      begin
         sync1_reg     <= {chip_select_n, read_n, high_byte_select, serial_clock_in};
         sync2_reg     <= sync1_reg;
         sclk_prev_reg <= sync2_reg[0];
         cs_prev_reg   <= sync2_reg[3];
         rd_prev_reg   <= sync2_reg[2];
      end
   end

   wire cs_n_s    = sync2_reg[3];
   wire rd_n_s    = sync2_reg[2];
   wire high_byte_select_s    = sync2_reg[1];
   wire sclk_s    = sync2_reg[0];
   wire sclk_rise = sclk_s && !sclk_prev_reg;
   wire sclk_fall = !sclk_s && sclk_prev_reg;
   wire cs_fall   = !cs_n_s && cs_prev_reg;
   wire rd_fall   = !rd_n_s && rd_prev_reg;
   wire rd_rise   = rd_n_s && !rd_prev_reg;
   wire par_mode_on = parallel_serial_select;

   // result fifo between the core and the output latches
   logic [11:0] fifo_data;
   logic        fifo_valid;
   wire         fifo_take;

   arr_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_D)) u_fifo
   (
      .clk       (clk),
      .rst       (rst),
      .in_valid  (conv_valid),
      .in_ready  (conv_ready),
      .in_data   (conv_result.value),
      .out_valid (fifo_valid),
      .out_ready (fifo_take),
      .out_data  (fifo_data)
   );

   // output latches: only replaced when a fresh result is taken
   logic [11:0] new_reg;
   logic [11:0] new_next;
   logic [7:0]  old_low_reg;
   logic [1:0]  rom_step_reg;
   logic [1:0]  rom_step_next;

   // serial frame starts at select fall, or at the first clock fall when aligned, whether or not a result is waiting
   typedef enum logic [1:0] {
      ARR_IDLE,
      ARR_WAIT_EDGE,
      ARR_SHIFT
   } arr_ser_e;

   arr_ser_e    ser_reg;
   arr_ser_e    ser_next;
   logic [4:0]  bit_reg;
   logic [15:0] shift_reg;
   logic        dout_reg;
   logic        dout_en_reg;

   wire ser_cs_active = !par_mode_on && !cs_n_s;
   wire ser_begin     = (ser_reg == ARR_IDLE) && ser_cs_active && cs_fall;
   wire aligned_go    = (ser_reg == ARR_WAIT_EDGE) && sclk_fall;
   wire imm_go        = ser_begin && (start_variant == ARR_IMMEDIATE);
   wire frame_go      = imm_go || aligned_go;

   // a parallel read that starts conversion takes the next result into the latch
   wire par_read      = par_mode_on && !cs_n_s && rd_fall;
   wire par_start     = par_read && !high_byte_select_s;
   assign fifo_take   = fifo_valid && (par_start || frame_go);

   // latch update, keeping the previous low byte for the rom sequence
   assign new_next      = fifo_take ? fifo_data : new_reg;
   assign rom_step_next = fifo_take ? 2'd1 :
                          (par_mode_on && rd_rise && !cs_n_s && rom_step_reg != 2'd0)
                          ? rom_step_reg + 2'd1 : rom_step_reg;

   // frame word: leading zero, 12 bits msb first, zeros after
   wire [15:0] frame_word = {1'b0, fifo_data, 3'b000};

   always_comb
   begin
      ser_next = ser_reg;
      case (ser_reg)
         ARR_IDLE:
            if (ser_begin && start_variant == ARR_CLOCK_ALIGNED)
               ser_next = ARR_WAIT_EDGE;
            else if (imm_go)
               ser_next = ARR_SHIFT;
         ARR_WAIT_EDGE:
            if (!ser_cs_active)
               ser_next = ARR_IDLE;
            else if (aligned_go)
               ser_next = ARR_SHIFT;
         ARR_SHIFT:
            if (!ser_cs_active)
               ser_next = ARR_IDLE;
         default:
            ser_next = ARR_IDLE;
      endcase
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         new_reg      <= RESULT_RESET;
         old_low_reg  <= RESULT_RESET[7:0];
         rom_step_reg <= 2'd0;
         ser_reg      <= ARR_IDLE;
      end
      else
      begin
         if (fifo_take)
            old_low_reg <= new_reg[7:0];
         new_reg      <= new_next;
         rom_step_reg <= rom_step_next;
         ser_reg      <= ser_next;
      end
   end

   // shifter: loaded at frame start, advances on sampled clock falling edges
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         shift_reg   <= 16'h0000;
         bit_reg     <= BITCNT_RESET;
         dout_reg    <= 1'b0;
         dout_en_reg <= 1'b0;
      end
      else if (!ser_cs_active)
      begin
         dout_en_reg <= 1'b0;
         dout_reg    <= 1'b0;
         bit_reg     <= BITCNT_RESET;
      end
      else if (frame_go)
      begin
         // leading zero goes out at once; aligned start in mode 0 lost its first bit to hiz
         shift_reg   <= {frame_word[14:0], 1'b0};
         dout_reg    <= frame_word[15];
         dout_en_reg <= 1'b1;
         bit_reg     <= 5'(FRAME_LEAD);
      end
      else if (ser_reg == ARR_SHIFT && sclk_fall)
      begin
         // change only on fall so data is settled at the next rise
         dout_reg  <= shift_reg[15];
         shift_reg <= {shift_reg[14:0], 1'b0};
         if (bit_reg != 5'(FRAME_BITS))
            bit_reg <= bit_reg + 5'd1;
      end
   end

   // frame strobe high while the leading bit is out, low afterwards
   wire strobe_level = (ser_reg == ARR_SHIFT) && (bit_reg == 5'(FRAME_LEAD));
   wire clk_out_en   = ser_cs_active && !rd_n_s;

   // parallel byte selection
   // in rom mode the read that takes a result still shows the previous low byte
   wire        rom_low_old = (par_mode == ARR_ROM) && (rom_step_reg == 2'd1);
   wire [7:0]  low_byte    = rom_low_old ? old_low_reg : new_reg[7:0];
   wire [7:0]  high_byte   = {HIGH_PAD, new_reg[11:8]};
   wire        pick_high   = high_byte_select_s;
   wire [7:0]  par_byte    = pick_high ? high_byte : low_byte;
   wire        par_drive   = par_mode_on && !cs_n_s && !rd_n_s;

   logic [7:0] bus_next;
   logic [7:0] oe_next;

   always_comb
   begin
      bus_next = 8'h00;
      oe_next  = 8'hFF;
      if (par_drive)
      begin
         bus_next = par_byte;
         oe_next  = 8'h00;
      end
      else if (!par_mode_on)
      begin
         bus_next = {dout_reg, sclk_s, strobe_level, 5'h00};
         oe_next  = {!dout_en_reg, !(clk_out_en && ser_reg != ARR_IDLE),
                     !(clk_out_en && ser_reg != ARR_IDLE), 5'h00};
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         data_out   <= 8'h00;
         data_oe_n  <= 8'hFF;
         conv_start <= 1'b0;
      end
      else
      begin
         data_out   <= bus_next;
         data_oe_n  <= oe_next;
         conv_start <= par_start || frame_go;
      end
   end
endmodule
